/* core/radio_cmd_core.sv */
// serial command interpreter and interrupt logic of the radio transceiver
// Function
// RULE1 - interrupt pin goes low while any unmasked done, ready or retry flag is set
// RULE2 - writing one to a flag bit clears it; pin releases when none remain
// RULE3 - each flag has a config mask bit; set masks it; all clear after reset
// RULE4 - three-bit pipe number updates at the interrupt pin's falling edge
// RULE5 - chip select falling starts a command; first byte is the command word
// RULE6 - status byte shifts out on miso while the command byte shifts in; code sends bits 6 to 0 only, bit 7 slot not driven
// RULE7 - command msb first; bank zero and bank one 9-14 data lsb byte first
// RULE8 - bank one registers 0-8 move data most significant byte first
// RULE9 - opcode 000 plus address reads one to five register bytes
// RULE10 - opcode 001 plus address writes one to five register bytes
// RULE11 - payload read returns oldest payload from byte zero, then removes it
// RULE12 - payload write loads a new transmit entry starting at byte zero
// RULE13 - transmit flush empties the whole transmit queue
// RULE14 - receive flush empties the receive queue
// RULE15 - repeat command resends last payload until new write or flush
// RULE16 - activate with 0x73 toggles the three extra feature commands
// RULE17 - inactive extra commands ignore writes and read back zeros
// RULE18 - activate with 0x53 toggles register bank, shown at status bit 7
// RULE19 - width read returns byte count of the head receive payload
// RULE20 - receive role queues reply payloads per pipe 0 to 5
// RULE21 - transmit role noreply write loads payload flagged without reply
// RULE22 - all-ones opcode does nothing and takes no data
// RULE23 - repeat flag set by repeat command, cleared by payload write or flush
// RULE24 - masks sit at config bits 6, 5 and 4; one suppresses
// RULE25 - chip select high ends command; extra bytes and unknown opcodes ignored
`timescale 1ns/100ps
module radio_cmd_core
  import radio_cmd_pkg::*;
(
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESETN_I,
  input  wire logic       SCK_I,
  input  wire logic       CHIP_SELECT_N_I,
  input  wire logic       MOSI_I,
  output logic            MISO_O,
  output logic            MISO_OE_O,
  output logic            IRQ_N_O,
  input  wire logic       TRANSMIT_DONE_SET_I,
  input  wire logic       RECEIVE_READY_SET_I,
  input  wire logic       RETRY_LIMIT_SET_I,
  input  wire logic [2:0] RX_PIPE_I,
  input  wire logic       TX_FULL_I,
  input  wire logic       TX_EMPTY_I,
  input  wire logic       RX_FULL_I,
  input  wire logic       RX_EMPTY_I,
  output logic [7:0]      TX_WR_DATA_O,
  output logic            TX_WR_STROBE_O,
  output logic [4:0]      TX_WR_INDEX_O,
  output logic [1:0]      TX_WR_KIND_O,
  output logic [2:0]      TX_WR_PIPE_O,
  output logic            TX_WR_COMMIT_O,
  output logic [4:0]      RX_RD_INDEX_O,
  input  wire logic [7:0] RX_RD_DATA_I,
  input  wire logic [5:0] RX_RD_WIDTH_I,
  output logic            RX_RD_POP_O,
  output logic            TX_FLUSH_O,
  output logic            RX_FLUSH_O,
  output logic            REUSE_ACTIVE_O,
  output logic            BANK_O,
  output logic            FEATURES_ACTIVE_O,
  output logic [7:0]      CONFIG_O
);

  // ===========================================================
  // register layout helpers
  function automatic logic [2:0] reg_len(input logic bank, input logic [4:0] addr);
    logic [2:0] len;
    len = LEN_SHORT;
    if (!bank && (addr == ADDR_WIDE_A || addr == ADDR_WIDE_B || addr == ADDR_WIDE_C))
      len = LEN_WIDE;
    else if (bank && addr <= BANK1_WIDE_LAST)
      len = LEN_BANK1;
    return len;
  endfunction

  // storage slot of transfer byte k; low bank one registers arrive reversed
  function automatic logic [2:0] reg_slot(input logic bank, input logic [4:0] addr,
                                          input logic [2:0] k);
    logic [2:0] len;
    len = reg_len(bank, addr);
    if (bank && addr <= BANK1_REVERSED_LAST)
      return 3'(len - 3'h1 - k);   // RULE8
    return k;                      // RULE7
  endfunction

  function automatic logic [7:0] read_byte(input logic bank, input logic [4:0] addr,
                                           input logic [5:0] k, input logic [7:0] status,
                                           input logic [7:0] qstat, input reg_file_t regs);
    logic [2:0] len;
    logic [7:0] val;
    len = reg_len(bank, addr);
    val = 8'h00;
    if (k >= {3'h0, len})
      val = 8'h00;                 // RULE25
    else if (!bank && addr == ADDR_STATUS)
      val = status;                // RULE18
    else if (!bank && addr == ADDR_QUEUE_STATUS)
      val = qstat;
    else
      val = regs[bank][addr][reg_slot(bank, addr, k[2:0])];   // RULE9
    return val;
  endfunction

  // ===========================================================
  // link side: runs on the host's serial clock
  link_frame_t frame, next_frame;
  link_xfer_t  xfer, next_xfer;
  link_out_t   lout, next_lout;
  core_state_t s, n;
  logic        link_rst_n;

  // frame logic restarts whenever chip select is high
  assign link_rst_n = RESETN_I & ~CHIP_SELECT_N_I;

  // input shifter, msb first
  always_comb
  begin
    next_frame = frame;
    next_frame.cnt = 3'(frame.cnt + 3'h1);
    next_frame.sh_in = {frame.sh_in[5:0], MOSI_I};   // RULE7
    if (frame.cnt == BIT_LAST)
      next_frame.got_byte = 1'b1;
  end

  always_ff @(posedge SCK_I or negedge link_rst_n)
  begin
    if (!link_rst_n)
      frame <= '0;
    else
      frame <= next_frame;
  end

  // completed byte handed over by toggle; survives chip select so no false event
  always_comb
  begin
    next_xfer = xfer;
    if (frame.cnt == BIT_LAST)
    begin
      next_xfer.rx_byte = {frame.sh_in, MOSI_I};
      next_xfer.rx_first = ~frame.got_byte;   // RULE5
      next_xfer.tog = ~xfer.tog;
    end
  end

  always_ff @(posedge SCK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      xfer <= '0;
    else
      xfer <= next_xfer;
  end

  // output shifter on the falling edge; the core's byte is held steady by then
  always_comb
  begin
    next_lout = lout;
    next_lout.oe = 1'b1;
    if (frame.cnt == 3'h1 && !frame.got_byte)
    begin
      next_lout.miso = s.tx_byte[6];                  // RULE6
      next_lout.out_sh = {s.tx_byte[5:0], 2'b00};
    end
    else if (frame.cnt == 3'h0 && frame.got_byte)
    begin
      next_lout.miso = s.tx_byte[7];
      next_lout.out_sh = {s.tx_byte[6:0], 1'b0};
    end
    else
    begin
      next_lout.miso = lout.out_sh[7];
      next_lout.out_sh = {lout.out_sh[6:0], 1'b0};
    end
  end

  always_ff @(negedge SCK_I or negedge link_rst_n)
  begin
    if (!link_rst_n)
      lout <= '0;
    else
      lout <= next_lout;
  end

  // ===========================================================
  // core side: command execution, flags and interrupt
  always_comb
  begin
    logic [7:0] status_byte;
    logic [7:0] queue_byte;
    logic       byte_ev;
    logic       cs_rise;
    logic [7:0] b;
    logic [2:0] clr;
    logic [2:0] mask;
    logic       role_rx;
    status_byte = {s.bank, s.receive_ready_flag, s.transmit_done_flag,
                   s.retry_limit_flag, s.pipe, TX_FULL_I};
    queue_byte = {1'b0, s.reuse, TX_FULL_I, TX_EMPTY_I, 2'b00, RX_FULL_I, RX_EMPTY_I};
    b = xfer.rx_byte;
    clr = 3'h0;
    role_rx = s.regs[0][ADDR_CONFIG][0][CONFIG_ROLE_BIT];
    byte_ev = (s.tog_s1 == s.tog_s2) && (s.tog_s2 != s.tog_seen);
    cs_rise = (s.cs_s1 == s.cs_s2) && s.cs_s2 && !s.cs_filt;
    mask = {s.regs[0][ADDR_CONFIG][0][MASK_RX_BIT], s.regs[0][ADDR_CONFIG][0][MASK_TX_BIT],
            s.regs[0][ADDR_CONFIG][0][MASK_RT_BIT]};   // RULE24 RULE3
    n = s;
    n.wr_strobe = 1'b0;
    n.wr_commit = 1'b0;
    n.rx_pop = 1'b0;
    n.tx_flush = 1'b0;
    n.rx_flush = 1'b0;
    n.rd_load = 1'b0;

    // three-stage synchronisers; an edge counts once stages two and three agree
    n.tog_s0 = xfer.tog;
    n.tog_s1 = s.tog_s0;
    n.tog_s2 = s.tog_s1;
    n.cs_s0 = CHIP_SELECT_N_I;
    n.cs_s1 = s.cs_s0;
    n.cs_s2 = s.cs_s1;
    if (s.tog_s1 == s.tog_s2)
      n.tog_seen = s.tog_s2;
    if (s.cs_s1 == s.cs_s2)
      n.cs_filt = s.cs_s2;

    // end of command: chip select high, or a new command word already here
    if (cs_rise || (byte_ev && xfer.rx_first && s.state != ST_IDLE))
    begin
      if (s.state == ST_PL_WR && s.idx != 6'h00)
        n.wr_commit = 1'b1;                   // RULE12
      if (s.state == ST_PL_RD && s.idx != 6'h00)
        n.rx_pop = 1'b1;                      // RULE11
      n.state = ST_IDLE;                      // RULE25
    end

    // payload byte fetched one cycle after its index was presented
    if (s.rd_load)
      n.tx_byte = RX_RD_DATA_I;               // RULE11

    if (byte_ev && xfer.rx_first)
    begin
      // command decode; response byte is prepared for the next byte slot
      n.idx = 6'h00;
      n.addr = b[4:0];
      n.tx_byte = 8'h00;
      n.state = ST_DISCARD;                   // RULE22 RULE25
      if (b[7:5] == CMD_REG_READ_TOP)
      begin
        n.state = ST_REG_RD;                  // RULE9
        n.tx_byte = read_byte(s.bank, b[4:0], 6'h00, status_byte, queue_byte, s.regs);
      end
      else if (b[7:5] == CMD_REG_WRITE_TOP)
        n.state = ST_REG_WR;                  // RULE10
      else if (b == CMD_READ_PAYLOAD)
      begin
        n.state = ST_PL_RD;
        n.rx_index = 5'h00;                   // RULE11
        n.rd_load = 1'b1;
      end
      else if (b == CMD_WRITE_PAYLOAD)
      begin
        n.state = ST_PL_WR;                   // RULE12
        n.wr_kind = KIND_NORMAL;
        n.wr_pipe = 3'h0;
        n.reuse = 1'b0;                       // RULE23
      end
      else if (b == CMD_FLUSH_TX)
      begin
        n.tx_flush = 1'b1;                    // RULE13
        n.reuse = 1'b0;                       // RULE23
      end
      else if (b == CMD_FLUSH_RX)
        n.rx_flush = 1'b1;                    // RULE14
      else if (b == CMD_REPEAT_LAST)
        n.reuse = 1'b1;                       // RULE15 RULE23
      else if (b == CMD_ACTIVATE)
        n.state = ST_ACT;
      else if (b == CMD_READ_WIDTH)
        n.tx_byte = s.features ? {2'b00, RX_RD_WIDTH_I} : 8'h00;   // RULE19 RULE17
      else if (b[7:3] == CMD_ACK_PAYLOAD_TOP)
      begin
        // refused out of receive role, when inactive, or for pipes above five
        if (s.features && role_rx && b[2:0] <= PIPE_LAST)
        begin
          n.state = ST_PL_WR;                 // RULE20 RULE17
          n.wr_kind = KIND_ACK;
          n.wr_pipe = b[2:0];
        end
      end
      else if (b == CMD_WRITE_NOREPLY)
      begin
        if (s.features && !role_rx)
        begin
          n.state = ST_PL_WR;                 // RULE21 RULE17
          n.wr_kind = KIND_NOREPLY;
          n.wr_pipe = 3'h0;
        end
      end
    end
    else if (byte_ev)
    begin
      // data bytes of the running command
      unique case (s.state)
        ST_IDLE:
          n.tx_byte = 8'h00;
        ST_REG_RD:
        begin
          if (s.idx < PAYLOAD_MAX)
            n.idx = 6'(s.idx + 6'h01);
          n.tx_byte = read_byte(s.bank, s.addr, 6'(s.idx + 6'h01), status_byte,
                                queue_byte, s.regs);   // RULE7 RULE8
        end
        ST_REG_WR:
        begin
          if (s.idx < {3'h0, reg_len(s.bank, s.addr)})
          begin
            if (!s.bank && s.addr == ADDR_STATUS)
              clr = {b[MASK_RX_BIT], b[MASK_TX_BIT], b[MASK_RT_BIT]};   // RULE2
            else if (!(!s.bank && s.addr == ADDR_QUEUE_STATUS))
              n.regs[s.bank][s.addr][reg_slot(s.bank, s.addr, s.idx[2:0])] = b;   // RULE10
            n.idx = 6'(s.idx + 6'h01);
          end
        end
        ST_PL_RD:
        begin
          if (s.idx < PAYLOAD_LAST)
          begin
            n.rx_index = 5'(s.idx + 6'h01);
            n.rd_load = 1'b1;
          end
          else
            n.tx_byte = 8'h00;                // RULE25
          if (s.idx < PAYLOAD_MAX)
            n.idx = 6'(s.idx + 6'h01);
        end
        ST_PL_WR:
        begin
          if (s.idx < PAYLOAD_MAX)
          begin
            n.wr_data = b;                    // RULE12
            n.wr_index = s.idx[4:0];
            n.wr_strobe = 1'b1;
            n.idx = 6'(s.idx + 6'h01);
          end
        end
        ST_ACT:
        begin
          if (b == ACT_FEATURES)
            n.features = ~s.features;         // RULE16
          else if (b == ACT_BANK)
            n.bank = ~s.bank;                 // RULE18
          n.state = ST_DISCARD;
        end
        ST_DISCARD:
          n.tx_byte = 8'h00;                  // RULE25
      endcase
    end

    // idle: keep the status byte ready for the next command word
    if (n.state == ST_IDLE)
      n.tx_byte = {n.bank, n.receive_ready_flag, n.transmit_done_flag,
                   n.retry_limit_flag, n.pipe, TX_FULL_I};   // RULE6

    // flags: a set in the same cycle as a clear wins
    n.receive_ready_flag = (s.receive_ready_flag & ~clr[2]) | RECEIVE_READY_SET_I;   // RULE2
    n.transmit_done_flag = (s.transmit_done_flag & ~clr[1]) | TRANSMIT_DONE_SET_I;
    n.retry_limit_flag = (s.retry_limit_flag & ~clr[0]) | RETRY_LIMIT_SET_I;

    // masked interrupt, active low
    n.irq_n = ~|({n.receive_ready_flag, n.transmit_done_flag, n.retry_limit_flag}
                 & ~mask);                    // RULE1

    // pipe number captured on the falling edge of the interrupt pin
    if (s.irq_n && !n.irq_n)
      n.pipe = RX_PIPE_I;                     // RULE4
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      s <= CORE_RESET;                        // RULE3
    else
      s <= n;
  end

  // ===========================================================
  // outputs, each straight from a flip-flop
  assign MISO_O = lout.miso;
  assign MISO_OE_O = lout.oe;
  assign IRQ_N_O = s.irq_n;
  assign TX_WR_DATA_O = s.wr_data;
  assign TX_WR_STROBE_O = s.wr_strobe;
  assign TX_WR_INDEX_O = s.wr_index;
  assign TX_WR_KIND_O = s.wr_kind;
  assign TX_WR_PIPE_O = s.wr_pipe;
  assign TX_WR_COMMIT_O = s.wr_commit;
  assign RX_RD_INDEX_O = s.rx_index;
  assign RX_RD_POP_O = s.rx_pop;
  assign TX_FLUSH_O = s.tx_flush;
  assign RX_FLUSH_O = s.rx_flush;
  assign REUSE_ACTIVE_O = s.reuse;
  assign BANK_O = s.bank;
  assign FEATURES_ACTIVE_O = s.features;
  assign CONFIG_O = s.regs[0][ADDR_CONFIG][0];

endmodule

/* core/radio_cmd_pkg.sv */
// constants and state types shared by the serial command block
package radio_cmd_pkg;

  // ===========================================================
  // command words
  localparam logic [2:0] CMD_REG_READ_TOP   = 3'h0;
  localparam logic [2:0] CMD_REG_WRITE_TOP  = 3'h1;
  localparam logic [7:0] CMD_READ_PAYLOAD   = 8'h61;
  localparam logic [7:0] CMD_WRITE_PAYLOAD  = 8'hA0;
  localparam logic [7:0] CMD_FLUSH_TX       = 8'hE1;
  localparam logic [7:0] CMD_FLUSH_RX       = 8'hE2;
  localparam logic [7:0] CMD_REPEAT_LAST    = 8'hE3;
  localparam logic [7:0] CMD_ACTIVATE       = 8'h50;
  localparam logic [7:0] CMD_READ_WIDTH     = 8'h60;
  localparam logic [4:0] CMD_ACK_PAYLOAD_TOP = 5'h15;
  localparam logic [7:0] CMD_WRITE_NOREPLY  = 8'hB0;
  localparam logic [7:0] CMD_NO_OP          = 8'hFF;
  localparam logic [7:0] ACT_FEATURES       = 8'h73;
  localparam logic [7:0] ACT_BANK           = 8'h53;

  // ===========================================================
  // register map and field positions
  localparam logic [4:0] ADDR_CONFIG        = 5'h00;
  localparam logic [4:0] ADDR_STATUS        = 5'h07;
  localparam logic [4:0] ADDR_QUEUE_STATUS  = 5'h17;
  localparam logic [4:0] ADDR_WIDE_A        = 5'h0A;
  localparam logic [4:0] ADDR_WIDE_B        = 5'h0B;
  localparam logic [4:0] ADDR_WIDE_C        = 5'h10;
  localparam logic [4:0] BANK1_REVERSED_LAST = 5'h08;
  localparam logic [4:0] BANK1_WIDE_LAST    = 5'h0E;
  localparam logic [2:0] LEN_SHORT          = 3'h1;
  localparam logic [2:0] LEN_WIDE           = 3'h5;
  localparam logic [2:0] LEN_BANK1          = 3'h4;
  localparam int         MASK_RX_BIT        = 6;
  localparam int         MASK_TX_BIT        = 5;
  localparam int         MASK_RT_BIT        = 4;
  localparam int         CONFIG_ROLE_BIT    = 0;
  localparam logic [7:0] CONFIG_RESET       = 8'h08;
  localparam logic [2:0] PIPE_RESET         = 3'h0;
  localparam logic [5:0] PAYLOAD_MAX        = 6'h20;
  localparam logic [5:0] PAYLOAD_LAST       = 6'h1F;
  localparam logic [2:0] PIPE_LAST          = 3'h5;
  localparam logic [2:0] BIT_LAST           = 3'h7;

  // payload entry kinds towards the transmit queue
  localparam logic [1:0] KIND_NORMAL        = 2'h0;
  localparam logic [1:0] KIND_ACK           = 2'h1;
  localparam logic [1:0] KIND_NOREPLY       = 2'h2;

  typedef logic [1:0][31:0][4:0][7:0] reg_file_t;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_REG_RD  = 7'h02,
    ST_REG_WR  = 7'h04,
    ST_PL_RD   = 7'h08,
    ST_PL_WR   = 7'h10,
    ST_ACT     = 7'h20,
    ST_DISCARD = 7'h40
  } cmd_state_t;

  // ===========================================================
  // state records, one per clocked process
  typedef struct packed {
    cmd_state_t state;
    logic tog_s0, tog_s1, tog_s2, tog_seen;
    logic cs_s0, cs_s1, cs_s2, cs_filt;
    logic [4:0] addr;
    logic [5:0] idx;
    logic receive_ready_flag, transmit_done_flag, retry_limit_flag;
    logic [2:0] pipe;
    logic irq_n, reuse, features, bank, rd_load;
    logic [7:0] tx_byte;
    logic [7:0] wr_data;
    logic [4:0] wr_index;
    logic [1:0] wr_kind;
    logic [2:0] wr_pipe;
    logic wr_strobe, wr_commit, rx_pop, tx_flush, rx_flush;
    logic [4:0] rx_index;
    reg_file_t regs;
  } core_state_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh_in;
    logic       got_byte;
  } link_frame_t;

  typedef struct packed {
    logic       tog;
    logic [7:0] rx_byte;
    logic       rx_first;
  } link_xfer_t;

  typedef struct packed {
    logic       miso;
    logic       oe;
    logic [7:0] out_sh;
  } link_out_t;

  localparam core_state_t CORE_RESET = '{state: ST_IDLE, cs_s0: 1'b1, cs_s1: 1'b1,
    cs_s2: 1'b1, cs_filt: 1'b1, irq_n: 1'b1, pipe: PIPE_RESET,
    regs: reg_file_t'(CONFIG_RESET), default: '0};

endpackage

/* sim/radio_cmd_core_monitor.sv */
// concurrent checks on the command block ports
`timescale 1ns/100ps
module radio_cmd_core_monitor
(
  input wire logic       CORE_CLK_I,
  input wire logic       RESETN_I,
  input wire logic       CHIP_SELECT_N_I,
  input wire logic       RECEIVE_READY_SET_I,
  input wire logic       TRANSMIT_DONE_SET_I,
  input wire logic       RETRY_LIMIT_SET_I,
  input wire logic       IRQ_N_O,
  input wire logic       MISO_OE_O,
  input wire logic       TX_WR_STROBE_O,
  input wire logic       TX_FLUSH_O,
  input wire logic       REUSE_ACTIVE_O,
  input wire logic [7:0] CONFIG_O
);
  // ===========================================================
  // assertions, one clock domain
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_irq_ready: assert property (RECEIVE_READY_SET_I && !CONFIG_O[6] |=> !IRQ_N_O)
    else $error("irq missed after ready flag");
  a_irq_done: assert property (TRANSMIT_DONE_SET_I && !CONFIG_O[5] |=> !IRQ_N_O)
    else $error("irq missed after done flag");
  a_irq_retry: assert property (RETRY_LIMIT_SET_I && !CONFIG_O[4] |=> !IRQ_N_O)
    else $error("irq missed after retry flag");
  // only a host write may release the pin, so a quiet bus keeps it low
  a_irq_hold: assert property ((!IRQ_N_O && CHIP_SELECT_N_I) [*8] |=> !IRQ_N_O)
    else $error("irq released without a write");
  a_oe_idle: assert property (CHIP_SELECT_N_I && $past(CHIP_SELECT_N_I) |-> !MISO_OE_O)
    else $error("miso driven while deselected");
  a_cfg_quiet: assert property (CHIP_SELECT_N_I [*8] |=> $stable(CONFIG_O))
    else $error("config changed without a command");
  a_strobe_quiet: assert property (CHIP_SELECT_N_I [*8] |-> !TX_WR_STROBE_O)
    else $error("payload strobe while bus idle");
  a_strobe_pulse: assert property (TX_WR_STROBE_O |=> !TX_WR_STROBE_O)
    else $error("payload strobe longer than a cycle");
  a_flush_reuse: assert property (TX_FLUSH_O |=> !TX_FLUSH_O ##1 !REUSE_ACTIVE_O)
    else $error("flush pulse or repeat clear wrong");
  c_irq_low: cover property ((!IRQ_N_O && CHIP_SELECT_N_I) [*8]);
  c_flush: cover property (TX_FLUSH_O);
  c_strobes: cover property (TX_WR_STROBE_O ##[1:40] TX_WR_STROBE_O);
endmodule

/* sim/radio_spi_command_and_irq_bench.sv */
// self-checking bench for the serial command and interrupt block
`timescale 1ns/100ps
module radio_spi_command_and_irq_bench;
  import radio_cmd_pkg::*;
  logic clk, rst_n, sck, cs_n, mosi, miso, irq_n, txf, hdone, strobe, commit, pop, txfl, rxfl;
  logic reuse, bank, feat;
  logic [2:0] set3, pipe;
  logic [7:0] cfg, wdata, rxb, w[5];
  logic [4:0] widx, rdidx;
  logic [1:0] kind;
  logic [5:0] rxw;
  logic [15:0] ke;
  logic [15:0] q[$], wq[$];
  logic [3:0] seen = 4'h0;
  int err_total = 0, check_count = 0, cyc = 0, seed;
  wire logic [7:0] rxd = {3'h0, rdidx} ^ 8'hA5;

  radio_cmd_core radio_cmd_core_i (.CORE_CLK_I(clk), .RESETN_I(rst_n), .SCK_I(sck),
    .CHIP_SELECT_N_I(cs_n), .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_O(), .IRQ_N_O(irq_n),
    .TRANSMIT_DONE_SET_I(set3[1]), .RECEIVE_READY_SET_I(set3[2]), .RETRY_LIMIT_SET_I(set3[0]),
    .RX_PIPE_I(pipe), .TX_FULL_I(txf), .TX_EMPTY_I(1'b0), .RX_FULL_I(1'b0), .RX_EMPTY_I(1'b0),
    .TX_WR_DATA_O(wdata), .TX_WR_STROBE_O(strobe), .TX_WR_INDEX_O(widx), .TX_WR_KIND_O(kind),
    .TX_WR_PIPE_O(), .TX_WR_COMMIT_O(commit), .RX_RD_INDEX_O(rdidx), .RX_RD_DATA_I(rxd),
    .RX_RD_WIDTH_I(rxw), .RX_RD_POP_O(pop), .TX_FLUSH_O(txfl), .RX_FLUSH_O(rxfl),
    .REUSE_ACTIVE_O(reuse), .BANK_O(bank), .FEATURES_ACTIVE_O(feat), .CONFIG_O(cfg));
  spi_host_model spi_host_model_i (.SCK_O(sck), .CS_N_O(cs_n), .MOSI_O(mosi), .MISO_I(miso),
    .RX_O(rxb), .DONE_O(hdone));

  // ===========================================================
  // clock, timeout and result watchers
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard, well above the roughly 1400 cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
    if (strobe === 1'b1)
      check("payload", {1'h0, kind, widx, wdata}, wq.pop_front());
    seen <= seen | {rxfl, txfl, pop, commit};
  end
  // each serial byte meets its note: {care mask, expected}
  always @(posedge hdone)
  begin
    ke = q.pop_front();
    check("miso", {8'h0, rxb & ke[15:8]}, {8'h0, ke[7:0] & ke[15:8]});
  end

  // ===========================================================
  // host helpers
  task automatic xb(input logic [7:0] b, input logic [7:0] e, input logic [7:0] k);
    q.push_back({k, e});
    spi_host_model_i.shift(b);
  endtask
  task automatic c2(input logic [7:0] c, input logic [7:0] d, input logic [7:0] e,
                    input logic [7:0] k);
    spi_host_model_i.open_frame();
    xb(c, 8'h00, 8'h00);
    xb(d, e, k);
    spi_host_model_i.close_frame();
  endtask
  task automatic c1(input logic [7:0] c);
    spi_host_model_i.open_frame();
    xb(c, 8'h00, 8'h00);
    spi_host_model_i.close_frame();
  endtask
  task automatic fire(input logic [2:0] s);
    @(posedge clk);
    set3 <= s;
    @(posedge clk);
    set3 <= 3'h0;
    repeat (3) @(posedge clk);
  endtask

  // ===========================================================
  // main sequence
  initial
  begin
    seed = 32'h87a55ef8;
    rst_n = 1'b0;
    set3 = 3'h0;
    txf = 1'b0;
    pipe = 3'h0;
    rxw = 6'h01;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    txf <= 1'($random(seed));
    pipe <= 3'($unsigned($random(seed)) % 6);
    rxw <= 6'($unsigned($random(seed)) % 32 + 1);
    for (int i = 0; i < 5; i++)
      w[i] = 8'($random(seed));
    repeat (6) @(posedge clk);
    check("config", cfg, CONFIG_RESET);
    fire(3'b100);
    check("irq", irq_n, 1'b0);
    spi_host_model_i.open_frame();
    xb(CMD_NO_OP, {2'b01, 2'b00, pipe, txf}, 8'h7F);
    spi_host_model_i.close_frame();
    c2({CMD_REG_WRITE_TOP, ADDR_STATUS}, 8'h40, 8'h00, 8'h00);
    check("irq", irq_n, 1'b1);
    // masked sources stay off the pin until unmasked
    c2({CMD_REG_WRITE_TOP, ADDR_CONFIG}, 8'h78, 8'h00, 8'h00);
    check("config", cfg, 8'h78);
    fire(3'b011);
    check("irq", irq_n, 1'b1);
    c2({CMD_REG_WRITE_TOP, ADDR_CONFIG}, 8'h08, 8'h00, 8'h00);
    check("irq", irq_n, 1'b0);
    c2({CMD_REG_WRITE_TOP, ADDR_STATUS}, 8'h30, 8'h00, 8'h00);
    check("irq", irq_n, 1'b1);
    // five byte register, then one byte beyond its length
    spi_host_model_i.open_frame();
    xb({CMD_REG_WRITE_TOP, ADDR_WIDE_A}, 8'h00, 8'h00);
    for (int i = 0; i < 5; i++)
      xb(w[i], 8'h00, 8'h00);
    spi_host_model_i.close_frame();
    spi_host_model_i.open_frame();
    xb({CMD_REG_READ_TOP, ADDR_WIDE_A}, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++)
      xb(8'hFF, (i < 5) ? w[i] : 8'h00, 8'hFF);
    spi_host_model_i.close_frame();
    // repeat flag against payload write and flush
    c1(CMD_REPEAT_LAST);
    check("reuse", reuse, 1'b1);
    spi_host_model_i.open_frame();
    xb(CMD_WRITE_PAYLOAD, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wq.push_back({1'h0, KIND_NORMAL, 5'(i), w[i]});
      xb(w[i], 8'h00, 8'h00);
    end
    spi_host_model_i.close_frame();
    check("reuse", reuse, 1'b0);
    c1(CMD_REPEAT_LAST);
    c1(CMD_FLUSH_TX);
    check("reuse", reuse, 1'b0);
    c1(CMD_FLUSH_RX);
    spi_host_model_i.open_frame();
    xb(CMD_READ_PAYLOAD, 8'h00, 8'h00);
    for (int i = 0; i < 3; i++)
      xb(8'hFF, {3'h0, 5'(i)} ^ 8'hA5, 8'hFF);
    spi_host_model_i.close_frame();
    // extra commands read zero until activated
    c2(CMD_READ_WIDTH, 8'hFF, 8'h00, 8'hFF);
    c2(CMD_ACTIVATE, ACT_FEATURES, 8'h00, 8'h00);
    check("features", feat, 1'b1);
    c2({CMD_REG_WRITE_TOP, ADDR_CONFIG}, 8'h09, 8'h00, 8'h00);
    wq.push_back({1'h0, KIND_ACK, 5'h0, w[4]});
    c2({CMD_ACK_PAYLOAD_TOP, 3'h2}, w[4], 8'h00, 8'h00);
    c2(CMD_READ_WIDTH, 8'hFF, {2'h0, rxw}, 8'hFF);
    c2(CMD_ACTIVATE, ACT_BANK, 8'h00, 8'h00);
    check("bank", bank, 1'b1);
    c2(CMD_ACTIVATE, ACT_BANK, 8'h00, 8'h00);
    c2({CMD_REG_READ_TOP, ADDR_STATUS}, 8'hFF, 8'h00, 8'h80);
    repeat (10) @(posedge clk);
    check("pulses", seen, 4'hF);
    wrap_up();
  end
endmodule

bind radio_cmd_core radio_cmd_core_monitor radio_cmd_core_monitor_i (.CORE_CLK_I(CORE_CLK_I),
  .RESETN_I(RESETN_I), .CHIP_SELECT_N_I(CHIP_SELECT_N_I),
  .RECEIVE_READY_SET_I(RECEIVE_READY_SET_I), .TRANSMIT_DONE_SET_I(TRANSMIT_DONE_SET_I),
  .RETRY_LIMIT_SET_I(RETRY_LIMIT_SET_I), .IRQ_N_O(IRQ_N_O), .MISO_OE_O(MISO_OE_O),
  .TX_WR_STROBE_O(TX_WR_STROBE_O), .TX_FLUSH_O(TX_FLUSH_O), .REUSE_ACTIVE_O(REUSE_ACTIVE_O),
  .CONFIG_O(CONFIG_O));

/* sim/spi_host_model.sv */
// host-side serial master driving the command block, mode 0
`timescale 1ns/100ps
module spi_host_model
(
  output logic            SCK_O,
  output logic            CS_N_O,
  output logic            MOSI_O,
  input  wire logic       MISO_I,
  output logic [7:0]      RX_O,
  output logic            DONE_O
);
  // ===========================================================
  // idle: clock stands low outside frames
  initial
  begin
    SCK_O = 1'b0;
    CS_N_O = 1'b1;
    MOSI_O = 1'b0;
    RX_O = 8'h00;
    DONE_O = 1'b0;
  end

  // every command opens with a select falling edge
  task automatic open_frame;
    CS_N_O = 1'b0;
    #32;
  endtask

  // deselect, then idle long enough for the core to finish
  task automatic close_frame;
    #32 CS_N_O = 1'b1;
    #400;
  endtask

  // one byte, msb first; gap leaves the core time for its answer
  task automatic shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      MOSI_O = b[i];
      #32 SCK_O = 1'b1;
      RX_O[i] = MISO_I;
      if (i == 0)
        #368 DONE_O = 1'b1;
      #32 SCK_O = 1'b0;
    end
    DONE_O = 1'b0;
  endtask
endmodule
